// *** logic/epcs_consts.vh ***
// Constants of the encoder parameter-channel command interpreter
`ifndef EPCS_CONSTS_VH
`define EPCS_CONSTS_VH

// Command bytes
`define EPCS_CMD_RD_POS      8'h42
`define EPCS_CMD_SET_POS     8'h43
`define EPCS_CMD_RD_CNT      8'h46
`define EPCS_CMD_INC_CNT     8'h47
`define EPCS_CMD_CLR_CNT     8'h49
`define EPCS_CMD_RD_DATA     8'h4A
`define EPCS_CMD_ST_DATA     8'h4B
`define EPCS_CMD_FLD_STAT    8'h4C
`define EPCS_CMD_MK_FLD      8'h4D
`define EPCS_CMD_FREE_MEM    8'h4E
`define EPCS_CMD_CHG_KEY     8'h4F
`define EPCS_CMD_RD_STAT     8'h50
`define EPCS_CMD_RD_TYPE     8'h52
`define EPCS_CMD_RESET       8'h53
`define EPCS_CMD_SET_ADDR    8'h55
`define EPCS_CMD_RD_SERIAL   8'h56
`define EPCS_CMD_CFG_IF      8'h57

// Status codes
`define EPCS_ST_OK           8'h00
`define EPCS_ST_TABLE        8'h03
`define EPCS_ST_WATCHDOG     8'h07
`define EPCS_ST_CHECKSUM     8'h0A
`define EPCS_ST_UNKNOWN      8'h0B
`define EPCS_ST_COUNT        8'h0C
`define EPCS_ST_ARG          8'h0D
`define EPCS_ST_PROTECT      8'h0E
`define EPCS_ST_KEY          8'h0F
`define EPCS_ST_FIXED        8'h10
`define EPCS_ST_ADDR         8'h11
`define EPCS_ST_NOFIELD      8'h12
`define EPCS_ST_ANALOG       8'h1C
`define EPCS_ST_CURRENT      8'h1D
`define EPCS_ST_SPEED        8'h1F

// Reset values
`define EPCS_KEY_RESET       8'h55
`define EPCS_ADDR_RESET      8'h40
`define EPCS_MODE_RESET      8'hE4

// Error answers carry the command byte with this bit set
`define EPCS_ERR_FLAG        8'h80

// Data field layout: four fields of up to 32 bytes in 128 bytes
`define EPCS_NFIELDS         8'h04
`define EPCS_FLD_MAX         8'h20
`define EPCS_MEM_BYTES       8'h80
`define EPCS_FLD0_SIZE       6'h10

// Frame buffer depth (command byte plus five data bytes)
`define EPCS_RX_DEPTH        3'h6
`define EPCS_RX_OVER         3'h7

`endif

// *** logic/epcs_mem.v ***
// Byte memory holding the data fields, registered read port
`timescale 1ns/1ps
`default_nettype none
module epcs_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    // Clock and reset
    input  wire          ref_clk_in,
    input  wire          rst_in,
    // Write port
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    // Read port
    input  wire [AW-1:0] rd_addr_in,
    output reg  [DW-1:0] rd_data_out
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_data_out <= {DW{1'b0}};
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule // epcs_mem
`default_nettype wire

// *** logic/epcs_pos.v ***
// Absolute position former with settable offset
`timescale 1ns/1ps
`default_nettype none
module epcs_pos #(
    parameter ST_W = 15,
    parameter MT_W = 12
) (
    // Clock and reset
    input  wire                 ref_clk_in,
    input  wire                 rst_in,
    // Raw position, counting up for clockwise rotation
    input  wire [ST_W-1:0]      singleturn_in,
    input  wire [MT_W-1:0]      multiturn_in,
    // Preset request
    input  wire                 set_in,
    input  wire [ST_W+MT_W-1:0] set_value_in,
    // Formed position
    output reg  [ST_W+MT_W-1:0] pos_out
);
    wire [ST_W+MT_W-1:0] raw;
    reg  [ST_W+MT_W-1:0] offset;

    assign raw = {multiturn_in, singleturn_in};

    // Offset arithmetic wraps modulo the full step count
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            offset  <= {(ST_W+MT_W){1'b0}};
            pos_out <= {(ST_W+MT_W){1'b0}};
        end else begin
            if (set_in) begin
                offset <= set_value_in - raw;
            end
            pos_out <= raw + offset;
        end
    end
endmodule // epcs_pos
`default_nettype wire

// *** logic/epcs_cmd.v ***
// Parameter-channel command interpreter and status reporter
`timescale 1ns/1ps
`default_nettype none
`include "epcs_consts.vh"
module epcs_cmd #(
    parameter [31:0] SERIAL_NUM = 32'h0000_0001, // Arbitrary value
    parameter [15:0] FW_VERSION = 16'h0001,      // Arbitrary value
    parameter [7:0]  TYPE_CODE  = 8'h01          // Arbitrary value
) (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // Received frame bytes from the framer
    input  wire [7:0]  rx_byte_in,
    input  wire        rx_valid_in,
    input  wire        rx_end_in,
    input  wire        rx_crc_ok_in,
    // Answer bytes to the framer
    output reg  [7:0]  tx_byte_out,
    output wire        tx_valid_out,
    output wire        tx_last_out,
    input  wire        tx_ready_in,
    // Raw position
    input  wire [14:0] singleturn_in,
    input  wire [11:0] multiturn_in,
    // Monitoring events
    input  wire        overspeed_in,
    input  wire        analog_fault_in,
    input  wire        tx_current_crit_in,
    input  wire        ram_error_in,
    input  wire        table_corrupt_in,
    input  wire        watchdog_reset_in,
    // Configuration and state
    output reg  [7:0]  node_addr_out,
    output reg  [7:0]  iface_mode_out,
    output wire        busy_out
);
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_EXEC = 3'd1;
    localparam [2:0] S_MEM  = 3'd2;
    localparam [2:0] S_LOAD = 3'd3;
    localparam [2:0] S_SEND = 3'd4;

    reg  [2:0]  state;
    reg  [7:0]  rxb [0:5];
    reg  [2:0]  rx_cnt;
    reg         crc_ok;
    reg  [7:0]  txb [0:6];
    reg  [2:0]  tx_len;
    reg  [2:0]  tx_idx;
    reg  [7:0]  key;
    reg  [15:0] counter;
    reg  [7:0]  proto_err;
    reg         lat_tab;
    reg         lat_wd;
    reg         lat_spd;
    reg         lat_ana;
    reg         lat_cur;
    reg  [3:0]  f_exist;
    reg  [3:0]  f_prot;
    reg  [3:0]  f_fixed;
    reg  [5:0]  f_size [0:3];
    reg  [7:0]  err;
    reg  [7:0]  status_code;
    reg  [7:0]  used;
    wire [7:0]  cmd;
    wire [3:0]  want_cnt;
    wire [1:0]  fi;
    wire        fld_bad;
    wire        fld_none;
    wire        addr_bad;
    wire        exec_ok;
    wire        clr_stat;
    wire        pos_set;
    wire        mem_we;
    wire [7:0]  mem_rd;
    wire [26:0] pos;
    wire [7:0]  avail;
    integer     i;
    integer     j;

    // Expected data byte count per command, bit 3 marks a known command
    function [3:0] epcs_expect;
        input [7:0] c;
        begin
            case (c)
                `EPCS_CMD_RD_POS:    epcs_expect = 4'h8;
                `EPCS_CMD_SET_POS:   epcs_expect = 4'hD;
                `EPCS_CMD_RD_CNT:    epcs_expect = 4'h8;
                `EPCS_CMD_INC_CNT:   epcs_expect = 4'h8;
                `EPCS_CMD_CLR_CNT:   epcs_expect = 4'h8;
                `EPCS_CMD_RD_DATA:   epcs_expect = 4'hA;
                `EPCS_CMD_ST_DATA:   epcs_expect = 4'hB;
                `EPCS_CMD_FLD_STAT:  epcs_expect = 4'h9;
                `EPCS_CMD_MK_FLD:    epcs_expect = 4'hA;
                `EPCS_CMD_FREE_MEM:  epcs_expect = 4'h8;
                `EPCS_CMD_CHG_KEY:   epcs_expect = 4'hA;
                `EPCS_CMD_RD_STAT:   epcs_expect = 4'h8;
                `EPCS_CMD_RD_TYPE:   epcs_expect = 4'h8;
                `EPCS_CMD_RESET:     epcs_expect = 4'h8;
                `EPCS_CMD_SET_ADDR:  epcs_expect = 4'hA;
                `EPCS_CMD_RD_SERIAL: epcs_expect = 4'h8;
                `EPCS_CMD_CFG_IF:    epcs_expect = 4'hA;
                default:             epcs_expect = 4'h0;
            endcase
        end
    endfunction

    assign cmd      = rxb[0];
    assign want_cnt = epcs_expect(cmd);
    assign fi       = rxb[1][1:0];
    assign fld_bad  = (rxb[1] >= `EPCS_NFIELDS);
    assign fld_none = ~f_exist[fi];
    assign addr_bad = (rxb[2] >= {2'b00, f_size[fi]});
    assign exec_ok  = (state == S_EXEC) && (err == `EPCS_ST_OK);
    assign clr_stat = exec_ok && ((cmd == `EPCS_CMD_RD_STAT) || (cmd == `EPCS_CMD_RESET));
    assign pos_set  = exec_ok && (cmd == `EPCS_CMD_SET_POS);
    assign mem_we   = exec_ok && (cmd == `EPCS_CMD_ST_DATA);
    assign avail    = `EPCS_MEM_BYTES - used;

    assign tx_valid_out = (state == S_SEND);
    assign tx_last_out  = (state == S_SEND) && (tx_idx == tx_len - 3'd1);
    assign busy_out     = (state != S_IDLE);

    always @* begin
        used = 8'h00;
        for (j = 0; j < 4; j = j + 1) begin
            used = used + {2'b00, f_size[j]};
        end
    end

    // Reported code: internal faults, then protocol, then monitoring
    always @* begin
        if (lat_tab) begin
            status_code = `EPCS_ST_TABLE;
        end else if (lat_wd) begin
            status_code = `EPCS_ST_WATCHDOG;
        end else if (proto_err != `EPCS_ST_OK) begin
            status_code = proto_err;
        end else if (lat_spd) begin
            status_code = `EPCS_ST_SPEED;
        end else if (lat_ana) begin
            status_code = `EPCS_ST_ANALOG;
        end else if (lat_cur) begin
            status_code = `EPCS_ST_CURRENT;
        end else begin
            status_code = `EPCS_ST_OK;
        end
    end

    // Frame checks in order of precedence
    always @* begin
        err = `EPCS_ST_OK;
        if (!crc_ok) begin
            err = `EPCS_ST_CHECKSUM;
        end else if (!want_cnt[3]) begin
            err = `EPCS_ST_UNKNOWN;
        end else if (rx_cnt != want_cnt[2:0] + 3'd1) begin
            err = `EPCS_ST_COUNT;
        end else begin
            case (cmd)
                `EPCS_CMD_SET_POS: begin
                    if (rxb[1] != key) begin
                        err = `EPCS_ST_KEY;
                    end else if (rxb[2][7:3] != 5'h00) begin
                        err = `EPCS_ST_ARG;
                    end
                end
                `EPCS_CMD_SET_ADDR, `EPCS_CMD_CFG_IF: begin
                    if (rxb[1] != key) begin
                        err = `EPCS_ST_KEY;
                    end
                end
                `EPCS_CMD_CHG_KEY: begin
                    if (rxb[1] != key) begin
                        err = `EPCS_ST_KEY;
                    end
                end
                `EPCS_CMD_RD_DATA, `EPCS_CMD_ST_DATA: begin
                    if (fld_bad) begin
                        err = `EPCS_ST_ARG;
                    end else if (fld_none) begin
                        err = `EPCS_ST_NOFIELD;
                    end else if (cmd == `EPCS_CMD_ST_DATA && f_prot[fi]) begin
                        err = `EPCS_ST_PROTECT;
                    end else if (addr_bad) begin
                        err = `EPCS_ST_ADDR;
                    end
                end
                `EPCS_CMD_FLD_STAT: begin
                    if (fld_bad) begin
                        err = `EPCS_ST_ARG;
                    end
                end
                `EPCS_CMD_MK_FLD: begin
                    if (fld_bad || rxb[2] == 8'h00 || rxb[2] > `EPCS_FLD_MAX) begin
                        err = `EPCS_ST_ARG;
                    end else if (f_exist[fi] && f_fixed[fi]) begin
                        err = `EPCS_ST_FIXED;
                    end
                end
                default: begin
                    err = `EPCS_ST_OK;
                end
            endcase
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state          <= S_IDLE;
            rx_cnt         <= 3'd0;
            crc_ok         <= 1'b0;
            tx_len         <= 3'd0;
            tx_idx         <= 3'd0;
            tx_byte_out    <= 8'h00;
            key            <= `EPCS_KEY_RESET;
            node_addr_out  <= `EPCS_ADDR_RESET;
            iface_mode_out <= `EPCS_MODE_RESET;
            counter        <= 16'h0000;
            proto_err      <= `EPCS_ST_OK;
            lat_tab        <= 1'b0;
            lat_wd         <= 1'b0;
            lat_spd        <= 1'b0;
            lat_ana        <= 1'b0;
            lat_cur        <= 1'b0;
            f_exist        <= 4'h1;
            f_prot         <= 4'h1;
            f_fixed        <= 4'h1;
            f_size[0]      <= `EPCS_FLD0_SIZE;
            for (i = 0; i < 7; i = i + 1) begin
                txb[i] <= 8'h00;
            end
            for (i = 0; i < 6; i = i + 1) begin
                rxb[i] <= 8'h00;
            end
            for (i = 1; i < 4; i = i + 1) begin
                f_size[i] <= 6'h00;
            end
        end else begin
            // Sticky fault flags, a new event wins over the clear
            lat_tab <= (lat_tab & ~clr_stat) | table_corrupt_in;
            lat_wd  <= (lat_wd & ~clr_stat) | watchdog_reset_in;
            lat_spd <= (lat_spd & ~clr_stat) | overspeed_in;
            lat_ana <= (lat_ana & ~clr_stat) | analog_fault_in;
            lat_cur <= (lat_cur & ~clr_stat) | tx_current_crit_in | ram_error_in;
            case (state)
                S_IDLE: begin
                    // Bytes are taken only while idle; the host waits for the answer
                    if (rx_valid_in) begin
                        if (rx_cnt < `EPCS_RX_DEPTH) begin
                            rxb[rx_cnt] <= rx_byte_in;
                            rx_cnt      <= rx_cnt + 3'd1;
                        end else begin
                            rx_cnt <= `EPCS_RX_OVER;
                        end
                    end
                    if (rx_end_in) begin
                        crc_ok <= rx_crc_ok_in;
                        if (rx_cnt != 3'd0) begin
                            state <= S_EXEC;
                        end
                    end
                end
                S_EXEC: begin
                    rx_cnt <= 3'd0;
                    txb[0] <= cmd;
                    tx_len <= 3'd1;
                    state  <= S_LOAD;
                    if (err != `EPCS_ST_OK) begin
                        txb[0]    <= cmd | `EPCS_ERR_FLAG;
                        txb[1]    <= err;
                        tx_len    <= 3'd2;
                        proto_err <= err;
                    end else begin
                        case (cmd)
                            `EPCS_CMD_RD_POS: begin
                                txb[1] <= {5'h00, pos[26:24]};
                                txb[2] <= pos[23:16];
                                txb[3] <= pos[15:8];
                                txb[4] <= pos[7:0];
                                tx_len <= 3'd5;
                            end
                            `EPCS_CMD_RD_CNT: begin
                                txb[1] <= counter[15:8];
                                txb[2] <= counter[7:0];
                                tx_len <= 3'd3;
                            end
                            `EPCS_CMD_INC_CNT: begin
                                counter <= counter + 16'h0001;
                            end
                            `EPCS_CMD_CLR_CNT: begin
                                counter <= 16'h0000;
                            end
                            `EPCS_CMD_RD_DATA: begin
                                tx_len <= 3'd2;
                                state  <= S_MEM;
                            end
                            `EPCS_CMD_FLD_STAT: begin
                                txb[1] <= {5'h00, f_exist[fi], f_prot[fi], f_fixed[fi]};
                                txb[2] <= {2'b00, f_size[fi]};
                                tx_len <= 3'd3;
                            end
                            `EPCS_CMD_MK_FLD: begin
                                f_exist[fi] <= 1'b1;
                                f_size[fi]  <= rxb[2][5:0];
                            end
                            `EPCS_CMD_FREE_MEM: begin
                                txb[1] <= avail;
                                tx_len <= 3'd2;
                            end
                            `EPCS_CMD_CHG_KEY: begin
                                key <= rxb[2];
                            end
                            `EPCS_CMD_RD_STAT: begin
                                txb[1] <= status_code;
                                tx_len <= 3'd2;
                                proto_err <= `EPCS_ST_OK;
                            end
                            `EPCS_CMD_RD_TYPE: begin
                                txb[1] <= TYPE_CODE;
                                tx_len <= 3'd2;
                            end
                            `EPCS_CMD_RESET: begin
                                proto_err <= `EPCS_ST_OK;
                            end
                            `EPCS_CMD_SET_ADDR: begin
                                node_addr_out <= rxb[2];
                            end
                            `EPCS_CMD_CFG_IF: begin
                                iface_mode_out <= rxb[2];
                            end
                            `EPCS_CMD_RD_SERIAL: begin
                                txb[1] <= SERIAL_NUM[31:24];
                                txb[2] <= SERIAL_NUM[23:16];
                                txb[3] <= SERIAL_NUM[15:8];
                                txb[4] <= SERIAL_NUM[7:0];
                                txb[5] <= FW_VERSION[15:8];
                                txb[6] <= FW_VERSION[7:0];
                                tx_len <= 3'd7;
                            end
                            default: begin
                                tx_len <= 3'd1;
                            end
                        endcase
                    end
                end
                S_MEM: begin
                    txb[1] <= mem_rd;
                    state  <= S_LOAD;
                end
                S_LOAD: begin
                    tx_byte_out <= txb[0];
                    tx_idx      <= 3'd0;
                    state       <= S_SEND;
                end
                S_SEND: begin
                    if (tx_ready_in) begin
                        if (tx_idx == tx_len - 3'd1) begin
                            state <= S_IDLE;
                        end else begin
                            tx_idx      <= tx_idx + 3'd1;
                            tx_byte_out <= txb[tx_idx + 3'd1];
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    epcs_pos #(
        .ST_W (15),
        .MT_W (12)
    ) u_pos (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .singleturn_in (singleturn_in),
        .multiturn_in  (multiturn_in),
        .set_in        (pos_set),
        .set_value_in  ({rxb[2][2:0], rxb[3], rxb[4], rxb[5]}),
        .pos_out       (pos)
    );

    epcs_mem #(
        .AW (7),
        .DW (8)
    ) u_mem (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  ({fi, rxb[2][4:0]}),
        .wr_data_in  (rxb[3]),
        .rd_addr_in  ({fi, rxb[2][4:0]}),
        .rd_data_out (mem_rd)
    );
endmodule // epcs_cmd
`default_nettype wire

// *** test/epcs_cmd_props.sv ***
// Checker of the answer handshake and configuration outputs of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module epcs_cmd_chk (
    // Clock, reset and frame input
    input wire logic       ref_clk_in, rst_in, rx_valid_in, rx_end_in, rx_crc_ok_in,
    // Answer and state
    input wire logic       tx_valid_out, tx_last_out, tx_ready_in, busy_out,
    input wire logic [7:0] tx_byte_out, node_addr_out, iface_mode_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    property p_answer_time; rx_valid_in && !busy_out ##1 rx_end_in |-> ##[3:4] $rose(tx_valid_out); endproperty
    a_answer_time: assert property (p_answer_time) else $error("answer start late");
    property p_crc;
        rx_valid_in && !busy_out ##1 rx_end_in && !rx_crc_ok_in |->
            ##3 tx_byte_out[7] ##[1:60] tx_last_out && tx_byte_out == 8'h0A;
    endproperty
    a_crc: assert property (p_crc) else $error("bad checksum not refused");
    property p_stand; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out); endproperty
    a_stand: assert property (p_stand) else $error("answer byte dropped");
    property p_last; tx_last_out |-> tx_valid_out && busy_out; endproperty
    a_last: assert property (p_last) else $error("last without valid");
    property p_done; tx_last_out && tx_ready_in |=> !tx_valid_out && !busy_out; endproperty
    a_done: assert property (p_done) else $error("answer not ended");
    property p_busy; busy_out && !(tx_last_out && tx_ready_in) |=> busy_out; endproperty
    a_busy: assert property (p_busy) else $error("busy dropped early");
    property p_rst; $fell(rst_in) |-> node_addr_out == 8'h40 && iface_mode_out == 8'hE4; endproperty
    a_rst: assert property (p_rst) else $error("delivery values wrong");
    property p_cfg; !busy_out |=> $stable(node_addr_out) && $stable(iface_mode_out); endproperty
    a_cfg: assert property (p_cfg) else $error("config changed without command");
    c_crc: cover property (rx_end_in && !rx_crc_ok_in);
    c_slow: cover property (tx_valid_out && !tx_ready_in);
    c_addr: cover property ($changed(node_addr_out));
endmodule // epcs_cmd_chk
bind epcs_cmd epcs_cmd_chk u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .rx_valid_in(rx_valid_in),
    .rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in), .tx_valid_out(tx_valid_out), .tx_last_out(tx_last_out),
    .tx_ready_in(tx_ready_in), .busy_out(busy_out), .tx_byte_out(tx_byte_out), .node_addr_out(node_addr_out),
    .iface_mode_out(iface_mode_out));
`default_nettype wire

// *** test/epcs_host.sv ***
// Drive controller model: sends one frame, then takes the whole answer
`timescale 1ns/1ps
`default_nettype none
module epcs_host (
    input  wire logic       clk_in,
    output logic [7:0]      rx_byte_out,
    output logic            rx_valid_out = 0, rx_end_out = 0, rx_crc_ok_out = 0, tx_ready_out = 0,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_valid_in, tx_last_in
);
    initial rx_byte_out = 8'h00;
    task xfer(input logic [47:0] f, input int n, input logic ok, input int slow,
              output logic [63:0] a, output int na);
        int i;
        a = '0;
        na = 0;
        for (i = 0; i < n; i++) begin
            @(negedge clk_in);
            rx_byte_out = f[47-8*i -: 8];
            rx_valid_out = 1;
        end
        @(negedge clk_in);
        rx_valid_out = 0;
        rx_byte_out = ~rx_byte_out;
        rx_end_out = 1;
        rx_crc_ok_out = ok;
        @(negedge clk_in);
        rx_end_out = 0;
        rx_crc_ok_out = ~ok;
        // Next frame only after the last answer byte is taken
        for (i = 0; i < 200; i++) begin
            @(negedge clk_in);
            rx_byte_out = ~rx_byte_out;
            tx_ready_out = (i % slow == 0);
            if (tx_valid_in === 1'b1 && tx_ready_out) begin
                a = {a[55:0], tx_byte_in};
                na++;
                if (tx_last_in === 1'b1) break;
            end
        end
        if (i == 200) na = -1;
        @(negedge clk_in);
        tx_ready_out = 0;
    endtask
endmodule // epcs_host
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk_in = 0, rst_in = 1, rx_valid, rx_end, rx_crc_ok, tx_ready, tx_valid, tx_last, busy;
    logic [7:0]  rx_byte, tx_byte, node_addr, iface_mode;
    logic [5:0]  ev = 6'h00;
    logic [14:0] st = 15'h0005;
    logic [11:0] mt = 12'h003;
    logic [63:0] ans;
    int          na, errors = 0, n_tests = 0, k;
    logic [7:0]  code [6] = '{8'h1F, 8'h1C, 8'h1D, 8'h1D, 8'h03, 8'h07};
    initial forever #25 ref_clk_in = ~ref_clk_in;
    epcs_host HOST (.clk_in(ref_clk_in), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid), .rx_end_out(rx_end),
        .rx_crc_ok_out(rx_crc_ok), .tx_ready_out(tx_ready), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid),
        .tx_last_in(tx_last));
    // Identity values are arbitrary
    epcs_cmd #(.SERIAL_NUM(32'h1234_5678), .FW_VERSION(16'h9ABC), .TYPE_CODE(8'h3C)) DUT (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
        .rx_end_in(rx_end), .rx_crc_ok_in(rx_crc_ok), .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
        .tx_last_out(tx_last), .tx_ready_in(tx_ready), .singleturn_in(st), .multiturn_in(mt),
        .overspeed_in(ev[0]), .analog_fault_in(ev[1]), .tx_current_crit_in(ev[2]), .ram_error_in(ev[3]),
        .table_corrupt_in(ev[4]), .watchdog_reset_in(ev[5]), .node_addr_out(node_addr),
        .iface_mode_out(iface_mode), .busy_out(busy));
    task end_of_test;
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task run(input logic [47:0] f, input int n, input logic ok, input int en, input logic [63:0] exp);
        HOST.xfer(f, n, ok, 2, ans, na);
        if (na < 0) begin
            errors++;
            end_of_test;
        end else begin
            chk("answer", {en[7:0], exp}, {na[7:0], ans});
        end
    endtask
    task t_codes;
        run(48'h5000_0000_0000, 1, 1, 2, 64'h5000);
        run(48'h5000_0000_0000, 1, 0, 2, 64'hD00A);
        run(48'h5000_0000_0000, 1, 1, 2, 64'h500A);
        run(48'h4C00_0000_0000, 1, 1, 2, 64'hCC0C);
        run(48'h4A05_0000_0000, 3, 1, 2, 64'hCA0D);
        run(48'h4B00_0011_0000, 4, 1, 2, 64'hCB0E);
        run(48'h4D00_0800_0000, 3, 1, 2, 64'hCD10);
        run(48'h4A00_1000_0000, 3, 1, 2, 64'hCA11);
        run(48'h4A01_0000_0000, 3, 1, 2, 64'hCA12);
        run(48'h4100_0000_0000, 1, 1, 2, 64'hC10B);
        run(48'h5300_0000_0000, 1, 1, 1, 64'h0053);
    endtask
    task t_fields;
        run(48'h4C00_0000_0000, 2, 1, 3, 64'h4C_0710);
        run(48'h4E00_0000_0000, 1, 1, 2, 64'h4E70);
        run(48'h4D01_2000_0000, 3, 1, 1, 64'h004D);
        run(48'h4E00_0000_0000, 1, 1, 2, 64'h4E50);
        run(48'h4C01_0000_0000, 2, 1, 3, 64'h4C_0420);
        run(48'h4B01_1FA5_0000, 4, 1, 1, 64'h004B);
        run(48'h4A01_1F00_0000, 3, 1, 2, 64'h4AA5);
        run(48'h4A01_2000_0000, 3, 1, 2, 64'hCA11);
    endtask
    task t_key;
        run(48'h5500_4100_0000, 3, 1, 2, 64'hD50F);
        chk("node address", 72'h40, {64'h0, node_addr});
        run(48'h5555_4100_0000, 3, 1, 1, 64'h0055);
        chk("node address", 72'h41, {64'h0, node_addr});
        run(48'h5755_1200_0000, 3, 1, 1, 64'h0057);
        chk("interface mode", 72'h12, {64'h0, iface_mode});
        run(48'h4F55_6600_0000, 3, 1, 1, 64'h004F);
        run(48'h5555_4200_0000, 3, 1, 2, 64'hD50F);
        run(48'h5566_4200_0000, 3, 1, 1, 64'h0055);
        chk("node address", 72'h42, {64'h0, node_addr});
        run(48'h5000_0000_0000, 1, 1, 2, 64'h500F);
    endtask
    task t_ident;
        run(48'h5600_0000_0000, 1, 1, 7, 64'h56_1234_5678_9ABC);
        run(48'h5200_0000_0000, 1, 1, 2, 64'h523C);
        run(48'h4700_0000_0000, 1, 1, 1, 64'h0047);
        run(48'h4600_0000_0000, 1, 1, 3, 64'h46_0001);
        run(48'h4900_0000_0000, 1, 1, 1, 64'h0049);
        run(48'h4600_0000_0000, 1, 1, 3, 64'h46_0000);
    endtask
    task t_events;
        for (k = 0; k < 6; k++) begin
            @(negedge ref_clk_in) ev = 6'h01 << k;
            @(negedge ref_clk_in) ev = 6'h00;
            run(48'h5000_0000_0000, 1, 1, 2, {56'h50, code[k]});
        end
        run(48'h5000_0000_0000, 1, 1, 2, 64'h5000);
    endtask
    task t_pos;
        run(48'h4200_0000_0000, 1, 1, 5, 64'h42_0001_8005);
        run(48'h4355_0123_4567, 6, 1, 2, 64'hC30F);
        run(48'h4366_0823_4567, 6, 1, 2, 64'hC30D);
        run(48'h4366_0123_4567, 6, 1, 1, 64'h0043);
        @(negedge ref_clk_in) st = st + 15'h0001;
        run(48'h4200_0000_0000, 1, 1, 5, 64'h42_0123_4568);
    endtask
    initial begin
        repeat (8) @(negedge ref_clk_in);
        rst_in = 0;
        t_codes;
        t_fields;
        t_key;
        t_ident;
        t_events;
        t_pos;
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
